// >>> src/rjd_ctrl.sv
/*
 * Receive jitter DCO control: corner configuration for the receive and
 * transmit oscillators, reference watch, sync source selection and receive
 * clock output selection, with an AXI4-Lite register slave.
 * Assumes aclk at 50 MHz; line clock, SYNC, single-rail clock and signal
 * loss arrive asynchronously and are synchronised here.
 */
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
// Behaviour
// RULE_01: Reset corner is 2 Hz E1, 6 Hz T1; slow bit gives 0.2/0.6 Hz.
// RULE_02: Extended enable makes 4-bit field pick corner; table derives P and I.
// RULE_03: With independent mode, 4-bit field is P, 5-bit field is I.
// RULE_04: One to three missing reference periods: keep regulating.
// RULE_05: Four or more missing with centre disable 0: centre to nominal.
// RULE_06: Four or more missing with centre disable 1: freeze frequency.
// RULE_07: Slave locks to line clock; signal loss falls back to SYNC.
// RULE_08: Fallback disable keeps line clock source on signal loss.
// RULE_09: Master free-runs without SYNC, locks when SYNC present.
// RULE_10: Sync frequency select 0 means line-rate SYNC, 1 means 8 kHz; code applies it in master mode only.
// RULE_11: Software keeps centre disable clear when SYNC is tied high.
// RULE_12: With 8 kHz SYNC software sets frequency select, centre disable 0.
// RULE_13: Slave without signal loss stays on line clock whatever SYNC does.
// RULE_14: Slave, loss, SYNC high: centre unless fallback disabled, then line.
// RULE_15: Slave, loss, SYNC running: lock to SYNC unless fallback disabled.
// RULE_16: Oscillator-sourced receive clock rate is 1, 2, 4 or 8 times line.
// RULE_17: Line-clock-sourced receive clock is fixed at the line rate.
// RULE_18: Transmit oscillator uses the same corner scheme with own controls.
// RULE_19: Missing periods counted on aclk, restarting at each reference edge.
`timescale 1ns/10ps
module rjd_ctrl
    import rjd_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Link side inputs
    input  wire logic        line_clock_in,
    input  wire logic        sync_in,
    input  wire logic        single_rail_clock_in,
    input  wire logic        signal_loss,
    // Oscillator control
    output rjd_pi_s          rx_pi,
    output rjd_pi_s          tx_pi,
    output rjd_osc_e         rx_osc_mode,
    output rjd_src_e         rx_sync_source,
    output logic             rx_ref_is_8k,
    output logic             rclk_from_osc,
    output logic [3:0]       rclk_multiplier
);

    // Registers
    logic [31:0] mode_r, mode_nxt;
    logic [31:0] rxc_r, rxc_nxt;
    logic [31:0] txc_r, txc_nxt;

    // Bus state
    logic        bvalid_r, bvalid_nxt;
    logic        rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0]  bresp_r, bresp_nxt;
    logic [1:0]  rresp_r, rresp_nxt;
    logic        do_write;
    logic [31:0] wmask;

    // Synchronisers: first stage read only by second
    logic [3:0]  s1_r, s2_r;
    logic        line_s, sync_s, srail_s, loss_s;

    // Reference watch
    logic [RJD_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [2:0]           miss_r, miss_nxt;
    logic                 ref_prev_r;
    logic                 ref_sel, ref_edge;
    logic [RJD_CNT_W-1:0] period;

    // Outputs registered
    rjd_osc_e    osc_r, osc_nxt;
    rjd_src_e    src_r, src_nxt;
    rjd_pi_s     rx_pi_w, tx_pi_w;
    rjd_pi_s     rx_pi_r, tx_pi_r;

    // Decoded configuration
    logic        t1_mode, master, freq8k, centre_disable, fallback_switch_disable;
    logic        pi_independent_mode, srail;
    logic [1:0]  rx_clock_rate_select;
    rjd_corner_s rx_cfg, tx_cfg;

    assign t1_mode                 = mode_r[RJD_B_T1];
    assign master                  = mode_r[RJD_B_MASTER];
    assign freq8k                  = mode_r[RJD_B_SYNC_FREQ];
    assign centre_disable          = mode_r[RJD_B_CENTRE_DIS];
    assign fallback_switch_disable = mode_r[RJD_B_FALLBACK_DIS];
    assign pi_independent_mode     = mode_r[RJD_B_PI_INDEP];
    assign srail                   = mode_r[RJD_B_SRAIL];
    assign rx_clock_rate_select    = mode_r[RJD_F_RATE_HI:RJD_F_RATE_LO];

    assign rx_cfg = '{slow: rxc_r[RJD_B_SLOW], ext_en: rxc_r[RJD_B_EXT_EN],
                      prop: rxc_r[RJD_F_PROP_HI:RJD_F_PROP_LO],
                      integ: rxc_r[RJD_F_INT_HI:RJD_F_INT_LO]};
    assign tx_cfg = '{slow: txc_r[RJD_B_SLOW], ext_en: txc_r[RJD_B_EXT_EN],
                      prop: txc_r[RJD_F_PROP_HI:RJD_F_PROP_LO],
                      integ: txc_r[RJD_F_INT_HI:RJD_F_INT_LO]};

    // Coefficient tables for both oscillators
    rjd_pi_table u_rx_table (
        .cfg                 (rx_cfg),
        .pi_independent_mode (pi_independent_mode),
        .t1_mode             (t1_mode),
        .pi                  (rx_pi_w)
    );

    rjd_pi_table u_tx_table (                                      // RULE_18
        .cfg                 (tx_cfg),
        .pi_independent_mode (pi_independent_mode),
        .t1_mode             (t1_mode),
        .pi                  (tx_pi_w)
    );

    // AXI4-Lite: take write when address and data are both present and no write response is pending
    assign do_write      = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    assign s_axi_awready = do_write;
    assign s_axi_wready  = do_write;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

    always_comb begin
        mode_nxt   = mode_r;
        rxc_nxt    = rxc_r;
        txc_nxt    = txc_r;
        bvalid_nxt = bvalid_r && !s_axi_bready;
        bresp_nxt  = bresp_r;
        rvalid_nxt = rvalid_r && !s_axi_rready;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (do_write) begin
            bvalid_nxt = 1'b1;
            bresp_nxt  = 2'b00;
            case (s_axi_awaddr[7:2])
                RJD_OFS_MODE[7:2]: begin
                    mode_nxt = ((mode_r & ~wmask) | (s_axi_wdata & wmask)) & 32'h0000_03FF;
                end
                RJD_OFS_RXCORN[7:2]: begin
                    rxc_nxt = ((rxc_r & ~wmask) | (s_axi_wdata & wmask)) & 32'h0000_1FF3;
                end
                RJD_OFS_TXCORN[7:2]: begin
                    txc_nxt = ((txc_r & ~wmask) | (s_axi_wdata & wmask)) & 32'h0000_1FF3;
                end
                default: begin
                    bresp_nxt = 2'b10;
                end
            endcase
        end
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = 2'b00;
            case (s_axi_araddr[7:2])
                RJD_OFS_MODE[7:2]:   rdata_nxt = mode_r;
                RJD_OFS_RXCORN[7:2]: rdata_nxt = rxc_r;
                RJD_OFS_TXCORN[7:2]: rdata_nxt = txc_r;
                RJD_OFS_STATUS[7:2]: rdata_nxt = {24'h00_0000, loss_s, miss_r, src_r, osc_r};
                RJD_OFS_RXPI[7:2]:   rdata_nxt = {23'h00_0000, rx_pi_r};
                RJD_OFS_TXPI[7:2]:   rdata_nxt = {23'h00_0000, tx_pi_r};
                default: begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = 2'b10;
                end
            endcase
        end
    end

    // Source choice from mode, signal loss and SYNC or single-rail clock activity
    always_comb begin
        src_nxt = RJD_SRC_LINE;
        if (master) begin
            src_nxt = (miss_r < 3'(RJD_MISS_LIMIT)) ? RJD_SRC_SYNC : RJD_SRC_FREE;   // RULE_09
        end else if (!loss_s || fallback_switch_disable) begin
            src_nxt = RJD_SRC_LINE;                                // RULE_13 RULE_08
        end else if (miss_r < 3'(RJD_MISS_LIMIT)) begin
            src_nxt = RJD_SRC_SYNC;                                // RULE_07 RULE_15
        end else begin
            src_nxt = RJD_SRC_FREE;                                // RULE_14
        end
    end

    // Reference watch on aclk
    assign ref_sel  = (!master && !loss_s) ? line_s : (srail ? srail_s : sync_s);   // RULE_04
    assign ref_edge = ref_sel && !ref_prev_r;
    always_comb begin
        if (master && freq8k) begin
            period = RJD_CNT_W'(RJD_PER_SLOW_CYC);                 // RULE_10
        end else if (t1_mode) begin
            period = RJD_CNT_W'(RJD_PER_FAST_T1_CYC);
        end else begin
            period = RJD_CNT_W'(RJD_PER_FAST_E1_CYC);
        end
    end

    always_comb begin
        cnt_nxt  = cnt_r;
        miss_nxt = miss_r;
        if (ref_edge) begin
            cnt_nxt  = '0;                                         // RULE_19
            miss_nxt = '0;
        end else if (cnt_r >= period) begin
            cnt_nxt = '0;
            if (miss_r < 3'(RJD_MISS_LIMIT)) begin
                miss_nxt = miss_r + 3'h1;
            end
        end else begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    // Oscillator behaviour
    always_comb begin
        case (src_nxt)
            RJD_SRC_LINE: osc_nxt = RJD_OSC_TRACK;                 // RULE_13
            RJD_SRC_SYNC: osc_nxt = RJD_OSC_TRACK;                 // RULE_04
            RJD_SRC_FREE: osc_nxt = centre_disable ? RJD_OSC_FREEZE : RJD_OSC_CENTRE;   // RULE_05 RULE_06 RULE_11
            default:      osc_nxt = RJD_OSC_CENTRE;
        endcase
    end

    // Configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= RJD_RST_MODE;                                // RULE_01
            rxc_r  <= RJD_RST_CORN;
            txc_r  <= RJD_RST_CORN;
        end else begin
            mode_r <= mode_nxt;
            rxc_r  <= rxc_nxt;
            txc_r  <= txc_nxt;
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= 2'b00;
        end else begin
            bvalid_r <= bvalid_nxt;
            bresp_r  <= bresp_nxt;
        end
    end

    // Read data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= 2'b00;
        end else begin
            rvalid_r <= rvalid_nxt;
            rdata_r  <= rdata_nxt;
            rresp_r  <= rresp_nxt;
        end
    end

    // Pin synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= 4'h0;
            s2_r <= 4'h0;
        end else begin
            s1_r <= {signal_loss, single_rail_clock_in, sync_in, line_clock_in};
            s2_r <= s1_r;
        end
    end

    // Reference watch state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_prev_r <= 1'b0;
            cnt_r      <= '0;
            miss_r     <= 3'h0;
        end else begin
            ref_prev_r <= ref_sel;
            cnt_r      <= cnt_nxt;
            miss_r     <= miss_nxt;
        end
    end

    // Oscillator behaviour and source
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_r <= RJD_OSC_TRACK;
            src_r <= RJD_SRC_LINE;
        end else begin
            osc_r <= osc_nxt;
            src_r <= src_nxt;
        end
    end

    // PI coefficients
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_pi_r <= '0;
            tx_pi_r <= '0;
        end else begin
            rx_pi_r <= rx_pi_w;
            tx_pi_r <= tx_pi_w;
        end
    end

    assign line_s  = s2_r[0];
    assign sync_s  = s2_r[1];
    assign srail_s = s2_r[2];
    assign loss_s  = s2_r[3];

    // Outputs
    assign rx_pi           = rx_pi_r;
    assign tx_pi           = tx_pi_r;
    assign rx_osc_mode     = osc_r;
    assign rx_sync_source  = src_r;
    assign rx_ref_is_8k    = master && freq8k;                     // RULE_10 RULE_12
    assign rclk_from_osc   = mode_r[RJD_B_RCLK_SRC];
    assign rclk_multiplier = mode_r[RJD_B_RCLK_SRC] ? (4'h1 << rx_clock_rate_select) : 4'h1;   // RULE_16 RULE_17

endmodule

// >>> src/rjd_pkg.sv
/*
 * Package for the receive jitter DCO control block: register map, field
 * positions, reset values, timing counts, PI coefficient types and enums.
 * Assumes a 50 MHz aclk and AXI4-Lite register access with 32-bit data.
 */
package rjd_pkg;

    // Register byte offsets
    localparam logic [7:0] RJD_OFS_MODE    = 8'h00;
    localparam logic [7:0] RJD_OFS_RXCORN  = 8'h04;
    localparam logic [7:0] RJD_OFS_TXCORN  = 8'h08;
    localparam logic [7:0] RJD_OFS_STATUS  = 8'h0C;
    localparam logic [7:0] RJD_OFS_RXPI    = 8'h10;
    localparam logic [7:0] RJD_OFS_TXPI    = 8'h14;

    // Mode register fields
    localparam int RJD_B_T1          = 0;
    localparam int RJD_B_MASTER      = 1;
    localparam int RJD_B_SYNC_FREQ   = 2;
    localparam int RJD_B_CENTRE_DIS  = 3;
    localparam int RJD_B_FALLBACK_DIS = 4;
    localparam int RJD_B_PI_INDEP    = 5;
    localparam int RJD_B_RCLK_SRC    = 6;
    localparam int RJD_B_SRAIL       = 7;
    localparam int RJD_F_RATE_LO     = 8;
    localparam int RJD_F_RATE_HI     = 9;

    // Corner register fields (rx and tx alike)
    localparam int RJD_B_SLOW        = 0;
    localparam int RJD_B_EXT_EN      = 1;
    localparam int RJD_F_PROP_LO     = 4;
    localparam int RJD_F_PROP_HI     = 7;
    localparam int RJD_F_INT_LO      = 8;
    localparam int RJD_F_INT_HI      = 12;

    // Reset values
    localparam logic [31:0] RJD_RST_MODE  = 32'h0000_0000;
    localparam logic [31:0] RJD_RST_CORN  = 32'h0000_0000;

    // Default corner coefficient sets (proportional, integral)
    localparam logic [3:0] RJD_P_FAST_E1 = 4'h4;
    localparam logic [4:0] RJD_I_FAST_E1 = 5'h0F;
    localparam logic [3:0] RJD_P_FAST_T1 = 4'h4;
    localparam logic [4:0] RJD_I_FAST_T1 = 5'h0F;
    localparam logic [3:0] RJD_P_SLOW    = 4'h8;
    localparam logic [4:0] RJD_I_SLOW    = 5'h13;
    localparam logic [3:0] RJD_P_MID     = 4'h6;
    localparam logic [4:0] RJD_I_MID     = 5'h12;

    // Reference watch timing: one reference period in aclk cycles at each rate
    localparam int RJD_CLK_HZ          = 50_000_000;
    localparam int RJD_REF_FAST_E1_HZ  = 2_048_000;
    localparam int RJD_REF_FAST_T1_HZ  = 1_544_000;
    localparam int RJD_REF_SLOW_HZ     = 8_000;
    localparam int RJD_PER_FAST_E1_CYC = (RJD_CLK_HZ + RJD_REF_FAST_E1_HZ - 1) / RJD_REF_FAST_E1_HZ;
    localparam int RJD_PER_FAST_T1_CYC = (RJD_CLK_HZ + RJD_REF_FAST_T1_HZ - 1) / RJD_REF_FAST_T1_HZ;
    localparam int RJD_PER_SLOW_CYC    = (RJD_CLK_HZ + RJD_REF_SLOW_HZ - 1) / RJD_REF_SLOW_HZ;
    localparam int RJD_MISS_LIMIT      = 4;
    localparam int RJD_CNT_W           = 16;

    // Oscillator behaviour and sync source
    typedef enum logic [1:0] {
        RJD_OSC_TRACK,
        RJD_OSC_CENTRE,
        RJD_OSC_FREEZE
    } rjd_osc_e;

    typedef enum logic [1:0] {
        RJD_SRC_LINE,
        RJD_SRC_SYNC,
        RJD_SRC_FREE
    } rjd_src_e;

    typedef struct packed {
        logic [3:0] prop;
        logic [4:0] integ;
    } rjd_pi_s;

    typedef struct packed {
        logic       slow;
        logic       ext_en;
        logic [3:0] prop;
        logic [4:0] integ;
    } rjd_corner_s;

endpackage

// >>> src/rjd_pi_table.sv
/*
 * PI coefficient selection for one oscillator.
 * Assumes the corner settings are stable register outputs on aclk.
 */
`timescale 1ns/10ps
module rjd_pi_table
    import rjd_pkg::*;
(
    // Configuration
    input  wire rjd_corner_s cfg,
    input  wire logic        pi_independent_mode,
    input  wire logic        t1_mode,
    // Coefficients
    output rjd_pi_s          pi
);

    always_comb begin
        if (cfg.ext_en && pi_independent_mode) begin
            pi.prop  = cfg.prop;                                   // RULE_03
            pi.integ = cfg.integ;                                  // RULE_03
        end else if (cfg.ext_en) begin
            pi.prop  = cfg.prop;                                   // RULE_02
            pi.integ = {1'b0, cfg.prop} + 5'h0B;                   // RULE_02
        end else if (cfg.slow) begin
            pi.prop  = RJD_P_SLOW;                                 // RULE_01
            pi.integ = RJD_I_SLOW;
        end else begin
            pi.prop  = t1_mode ? RJD_P_FAST_T1 : RJD_P_FAST_E1;   // RULE_01
            pi.integ = t1_mode ? RJD_I_FAST_T1 : RJD_I_FAST_E1;
        end
    end

endmodule

// >>> bench/rjd_ctrl_properties.sv
/*
 * Checker for rjd_ctrl: register handshake, reset state and receive clock rate.
 * Assumes it is bound to rjd_ctrl and sees only its ports.
 */
`timescale 1ns/10ps
module rjd_ctrl_checker
    import rjd_pkg::*;
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Oscillator control
    input wire rjd_pi_s     rx_pi,
    input wire rjd_osc_e    rx_osc_mode,
    input wire rjd_src_e    rx_sync_source,
    input wire logic        rclk_from_osc,
    input wire logic [3:0]  rclk_multiplier
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_write_take: assert property (s_axi_wready == s_axi_awready
        && s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)) else $error("write ready wrong");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid) else $error("no write response");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("no read data");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_reset_state: assert property ($rose(aresetn) |=> rx_pi == {RJD_P_FAST_E1, RJD_I_FAST_E1}
        && rx_osc_mode == RJD_OSC_TRACK && rx_sync_source == RJD_SRC_LINE) else $error("bad reset state");
    a_line_rate: assert property (!rclk_from_osc |-> rclk_multiplier == 4'h1) else $error("line rate wrong");
    a_osc_rate: assert property (rclk_from_osc |-> $onehot(rclk_multiplier)) else $error("osc rate wrong");

    c_centre: cover property (rx_osc_mode == RJD_OSC_CENTRE);
    c_freeze: cover property (rx_osc_mode == RJD_OSC_FREEZE);
    c_sync: cover property (rx_sync_source == RJD_SRC_SYNC);
    c_rate8: cover property (rclk_from_osc && rclk_multiplier == 4'h8);
endmodule

bind rjd_ctrl rjd_ctrl_checker u_chk (.*);

// >>> bench/rjd_link_model.sv
/*
 * Far side model: recovered line clock and SYNC reference.
 * Assumes the bench starts and stops each clock; a stopped SYNC sits at sync_hi.
 */
`timescale 1ns/10ps
module rjd_link_model #(
    parameter real HALF_NS = 80.0
)(
    // Controls
    input  wire logic line_run,
    input  wire logic sync_run,
    input  wire logic sync_hi,
    // Clocks
    output logic      line_clock_in,
    output logic      sync_in
);
    initial begin
        line_clock_in = 1'b0;
        sync_in = 1'b1;
        #3.3;
        forever begin
            #(HALF_NS);
            line_clock_in = line_run ? ~line_clock_in : 1'b0;
            sync_in = sync_run ? ~sync_in : sync_hi;
        end
    end
endmodule

// >>> bench/rjd_ctrl_test.sv
/*
 * Self-checking bench for rjd_ctrl over its register bus and link inputs.
 * Assumes the checker is bound and the link model drives the line clock and SYNC.
 */
`timescale 1ns/10ps
module rjd_ctrl_test
    import rjd_pkg::*;
();
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
    logic [3:0]  s_axi_wstrb, rclk_multiplier;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic        line_clock_in, sync_in, single_rail_clock_in, signal_loss;
    logic        rx_ref_is_8k, rclk_from_osc, line_run, sync_run, sync_hi;
    rjd_pi_s     rx_pi, tx_pi;
    rjd_osc_e    rx_osc_mode;
    rjd_src_e    rx_sync_source;
    int          bad_count, total_checks;

    rjd_ctrl dut (.*);
    rjd_link_model u_link (.line_run(line_run), .sync_run(sync_run), .sync_hi(sync_hi),
        .line_clock_in(line_clock_in), .sync_in(sync_in));

    always #10 aclk = ~aclk;

    task final_report;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Waits for: 0 write take, 1 write response, 2 read take, 3 read data
    task wait_edge(input int sel);
        int   n;
        logic hit;
        n = 0;
        do begin
            @(negedge aclk);
            hit = (sel == 0 && s_axi_awready === 1'b1) || (sel == 1 && s_axi_bvalid === 1'b1)
                || (sel == 2 && s_axi_arready === 1'b1) || (sel == 3 && s_axi_rvalid === 1'b1);
            if (hit && sel == 1) rsp = s_axi_bresp;
            if (hit && sel == 3) begin
                rd_d = s_axi_rdata;
                rsp  = s_axi_rresp;
            end
            @(posedge aclk);
            n++;
        end while (!hit && n < 100);
        if (!hit) begin
            bad_count++;
            final_report;
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        wait_edge(0);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        wait_edge(1);
        s_axi_bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        wait_edge(2);
        s_axi_arvalid <= 1'b0;
        wait_edge(3);
        s_axi_rready <= 1'b0;
    endtask

    task run(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task cfg(input logic [31:0] m, input logic [31:0] r, input logic [31:0] x);
        wr(RJD_OFS_MODE, m);
        wr(RJD_OFS_RXCORN, r);
        wr(RJD_OFS_TXCORN, x);
        run(10);
    endtask

    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, single_rail_clock_in, signal_loss, sync_run} = '0;
        {bad_count, total_checks} = '0;
        s_axi_wstrb = 4'hF;
        line_run = 1'b1;
        sync_hi = 1'b1;
        run(6);
        aresetn <= 1'b1;
        rd(RJD_OFS_MODE);
        chk(rd_d, RJD_RST_MODE);
        rd(RJD_OFS_RXCORN);
        chk(rd_d, RJD_RST_CORN);
        chk(rx_pi, {RJD_P_FAST_E1, RJD_I_FAST_E1});
        chk(tx_pi, {RJD_P_FAST_E1, RJD_I_FAST_E1});
        cfg(32'h1, 32'h0, 32'h0);
        chk(rx_pi, {RJD_P_FAST_T1, RJD_I_FAST_T1});
        cfg(32'h0, 32'h1, 32'h0);
        chk(rx_pi, {RJD_P_SLOW, RJD_I_SLOW});
        chk(tx_pi, {RJD_P_FAST_E1, RJD_I_FAST_E1});
        cfg(32'h0, 32'h0, 32'h1);
        chk(tx_pi, {RJD_P_SLOW, RJD_I_SLOW});
        cfg(32'h0, 32'h72, 32'h42);
        chk(rx_pi, {4'h7, 5'h12});
        chk(tx_pi, {4'h4, 5'h0F});
        cfg(32'h20, 32'h1FA2, 32'h0352);
        chk(rx_pi, {4'hA, 5'h1F});
        chk(tx_pi, {4'h5, 5'h03});
        cfg(32'h20, 32'h1F01, 32'h0);
        chk(rx_pi, {RJD_P_SLOW, RJD_I_SLOW});
        wr(RJD_OFS_RXPI, 32'h1);
        chk(rsp, 2'b10);
        rd(8'h40);
        chk(rsp, 2'b10);
        chk(rd_d, 32'h0);
        cfg(32'h0, 32'h0, 32'h0);
        chk(rx_sync_source, RJD_SRC_LINE);
        sync_run <= 1'b1;
        run(20);
        chk(rx_sync_source, RJD_SRC_LINE);
        signal_loss <= 1'b1;
        run(20);
        chk(rx_sync_source, RJD_SRC_SYNC);
        chk(rx_osc_mode, RJD_OSC_TRACK);
        cfg(32'h10, 32'h0, 32'h0);
        chk(rx_sync_source, RJD_SRC_LINE);
        sync_run <= 1'b0;
        run(200);
        chk(rx_sync_source, RJD_SRC_LINE);
        chk(rx_osc_mode, RJD_OSC_TRACK);
        cfg(32'h0, 32'h0, 32'h0);
        run(200);
        chk(rx_osc_mode, RJD_OSC_CENTRE);
        signal_loss <= 1'b0;
        sync_run <= 1'b1;
        cfg(32'h2, 32'h0, 32'h0);
        chk(rx_sync_source, RJD_SRC_SYNC);
        sync_hi <= 1'b0;
        for (int g = 0; g < 2; g++) begin
            sync_run <= 1'b0;
            run(60);
            chk(rx_osc_mode, RJD_OSC_TRACK);
            sync_run <= 1'b1;
            run(20);
        end
        sync_run <= 1'b0;
        run(200);
        chk(rx_sync_source, RJD_SRC_FREE);
        chk(rx_osc_mode, RJD_OSC_CENTRE);
        cfg(32'h0A, 32'h0, 32'h0);
        chk(rx_osc_mode, RJD_OSC_FREEZE);
        sync_run <= 1'b1;
        cfg(32'h06, 32'h0, 32'h0);
        chk(rx_ref_is_8k, 1'b1);
        cfg(32'h04, 32'h0, 32'h0);
        chk(rx_ref_is_8k, 1'b0);
        cfg(32'h82, 32'h0, 32'h0);
        run(200);
        chk(rx_sync_source, RJD_SRC_FREE);
        repeat (40) begin
            single_rail_clock_in <= ~single_rail_clock_in;
            run(4);
        end
        chk(rx_sync_source, RJD_SRC_SYNC);
        for (int r = 0; r < 4; r++) begin
            cfg(32'h40 | (r << 8), 32'h0, 32'h0);
            chk(rclk_multiplier, 32'h1 << r);
            chk(rclk_from_osc, 1'b1);
            cfg(r << 8, 32'h0, 32'h0);
            chk(rclk_multiplier, 32'h1);
            chk(rclk_from_osc, 1'b0);
        end
        final_report;
    end
endmodule
